// >>> inc/ricd_pkg.sv
// Overview of operation
// R1: bypass bit 1 routes primary and secondary paths around the glitch-free mux.
// R2: keep-on bit 0 turns secondary crystal buffer off after return to primary.
// R3: keep-on bit 1 keeps secondary crystal buffer on after return to primary.
// R4: secondary gain bit 0 is minimum, 1 maximum; resets to 1.
// R5: primary gain bit 0 is minimum, 1 maximum; resets to 1.
// R6: synth A reference divider code 0 bypasses, code n divides by n+1.
// R7: synth A M divider code 0 bypasses, code n divides by n+1.
// R8: synth B reference divider code 0 bypasses, code n divides by n+1.
// R9: automatic selection prefers primary and returns to it when usable.
// R10: nonvolatile fields load at power-up; software writes override until reload.
package ricd_pkg;
  // =====================================
  // register word indices, compared with paddr_i[7:2]
  localparam logic [7:0] RICD_CTRL_IDX = 8'h33;
  localparam logic [7:0] RICD_ARDIV_IDX = 8'h34;
  localparam logic [7:0] RICD_AMDIV_IDX = 8'h35;
  localparam logic [7:0] RICD_BRDIV_IDX = 8'h36;
  localparam logic [7:0] RICD_BMDIV_IDX = 8'h37;
  localparam logic [7:0] RICD_SEL_IDX = 8'h38;
  localparam logic [7:0] RICD_STAT_IDX = 8'h39;
  // =====================================
  // field positions and reset values
  localparam int RICD_BYP_BIT = 7;
  localparam int RICD_KEEP_BIT = 2;
  localparam int RICD_SGAIN_BIT = 1;
  localparam int RICD_PGAIN_BIT = 0;
  localparam logic [7:0] RICD_CTRL_RST = 8'h03;
  localparam logic [7:0] RICD_DIV_RST = 8'h00;
  localparam logic [1:0] RICD_SEL_RST = 2'h1;
  localparam logic [1:0] RICD_SEL_AUTO = 2'h0;
  localparam logic [1:0] RICD_SEL_PIN = 2'h1;
  localparam logic [1:0] RICD_SEL_PRI = 2'h2;
  localparam logic [1:0] RICD_SEL_SEC = 2'h3;
  localparam int RICD_RDIV_W = 3;
  localparam int RICD_MDIV_W = 5;
  // =====================================
  // carried settings
  typedef struct packed {
    logic ref_mux_bypass;
    logic [3:0] rsvd;
    logic sec_xtal_keep_on;
    logic sec_buf_gain_sel;
    logic pri_buf_gain_sel;
  } ricd_ctrl_t;
  typedef struct packed {
    logic [RICD_RDIV_W-1:0] synth_a_ref_div;
    logic [RICD_MDIV_W-1:0] synth_a_m_div;
    logic [RICD_RDIV_W-1:0] synth_b_ref_div;
    logic [RICD_MDIV_W-1:0] synth_b_m_div;
  } ricd_div_t;
endpackage

// >>> core/ricd_top.sv
`timescale 1ns/1ns
module ricd_top
  import ricd_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // nonvolatile image, loaded on nv_load_i pulse
  input wire logic nv_load_i,
  input wire logic [7:0] nv_ctrl_i,
  input wire logic [7:0] nv_ardiv_i,
  input wire logic [7:0] nv_amdiv_i,
  input wire logic [7:0] nv_brdiv_i,
  input wire logic [7:0] nv_bmdiv_i,
  // reference status pins
  input wire logic pri_valid_i,
  input wire logic ref_sel_pin_i,
  // analog controls
  output ricd_ctrl_t ctrl_o,
  output ricd_div_t div_o,
  output logic synth_a_use_sec_o,
  output logic sec_xtal_en_o,
  output logic synth_a_ref_bypass_o,
  output logic synth_a_m_bypass_o,
  output logic synth_b_ref_bypass_o,
  output logic [3:0] synth_a_ref_ratio_o,
  output logic [5:0] synth_a_m_ratio_o,
  output logic [3:0] synth_b_ref_ratio_o
);
  // =====================================
  // pin synchronisers
  logic pv_s1, pv_s2, rs_s1, rs_s2;
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      // primary assumed usable, so reset causes no false switch
      pv_s1 <= 1'b1;
      pv_s2 <= 1'b1;
      rs_s1 <= 1'b0;
      rs_s2 <= 1'b0;
    end
    else
    begin
      pv_s1 <= pri_valid_i;
      pv_s2 <= pv_s1;
      rs_s1 <= ref_sel_pin_i;
      rs_s2 <= rs_s1;
    end
  end

  // =====================================
  // apb decode; zero wait states, unmapped gives pslverr
  logic wr_en, hit;
  logic [1:0] synth_a_input_sel;
  ricd_ctrl_t ctrl;
  ricd_div_t div;
  logic [7:0] rd_byte;
  assign wr_en = psel_i && penable_i && pwrite_i;
  assign pready_o = 1'b1;
  logic [7:0] addr_idx;
  // word index; an unaligned address maps to nothing
  assign addr_idx = (paddr_i[1:0] == 2'h0) ? {2'h0, paddr_i[7:2]} : 8'hFF;

  always_comb
  begin
    hit = 1'b1;
    rd_byte = 8'h00;
    unique case (addr_idx)
      RICD_CTRL_IDX: rd_byte = ctrl;
      RICD_ARDIV_IDX: rd_byte = {5'h00, div.synth_a_ref_div};
      RICD_AMDIV_IDX: rd_byte = {3'h0, div.synth_a_m_div};
      RICD_BRDIV_IDX: rd_byte = {5'h00, div.synth_b_ref_div};
      RICD_BMDIV_IDX: rd_byte = {3'h0, div.synth_b_m_div};
      RICD_SEL_IDX: rd_byte = {6'h00, synth_a_input_sel};
      RICD_STAT_IDX: rd_byte = {5'h00, sec_xtal_en_o, synth_a_use_sec_o,
        pv_s2};
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      prdata_o <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end
    else
    begin
      prdata_o <= (psel_i && !penable_i) ? {24'h000000, rd_byte} : prdata_o;
      pslverr_o <= psel_i && !penable_i && !hit;
    end
  end

  // =====================================
  // settings; later write beats nv load only when later [R10]
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ctrl <= RICD_CTRL_RST; // [R4] [R5]
      div <= '0; // [R6] [R7] [R8]
      synth_a_input_sel <= RICD_SEL_RST;
    end
    else if (nv_load_i)
    begin
      ctrl <= nv_ctrl_i; // [R10]
      div.synth_a_ref_div <= nv_ardiv_i[RICD_RDIV_W-1:0];
      div.synth_a_m_div <= nv_amdiv_i[RICD_MDIV_W-1:0];
      div.synth_b_ref_div <= nv_brdiv_i[RICD_RDIV_W-1:0];
      div.synth_b_m_div <= nv_bmdiv_i[RICD_MDIV_W-1:0];
    end
    else if (wr_en)
    begin
      unique case (addr_idx)
        RICD_CTRL_IDX: ctrl <= pwdata_i[7:0];
        RICD_ARDIV_IDX: div.synth_a_ref_div <= pwdata_i[RICD_RDIV_W-1:0];
        RICD_AMDIV_IDX: div.synth_a_m_div <= pwdata_i[RICD_MDIV_W-1:0];
        RICD_BRDIV_IDX: div.synth_b_ref_div <= pwdata_i[RICD_RDIV_W-1:0];
        RICD_BMDIV_IDX: div.synth_b_m_div <= pwdata_i[RICD_MDIV_W-1:0];
        RICD_SEL_IDX: synth_a_input_sel <= pwdata_i[1:0];
        default: ;
      endcase
    end
  end
  assign ctrl_o = ctrl; // [R1] [R4] [R5]
  assign div_o = div;

  // =====================================
  // divider ratios: code 0 bypass, else n+1
  assign synth_a_ref_bypass_o = (div.synth_a_ref_div == '0); // [R6]
  assign synth_a_m_bypass_o = (div.synth_a_m_div == '0); // [R7]
  assign synth_b_ref_bypass_o = (div.synth_b_ref_div == '0); // [R8]
  assign synth_a_ref_ratio_o = {1'b0, div.synth_a_ref_div} + 4'h1; // [R6]
  assign synth_a_m_ratio_o = {1'b0, div.synth_a_m_div} + 6'h01; // [R7]
  assign synth_b_ref_ratio_o = {1'b0, div.synth_b_ref_div} + 4'h1; // [R8]

  // =====================================
  // input selection; in pin mode, pin low forces primary, high runs automatic
  logic want_sec, use_sec, seen_sec;
  always_comb
  begin
    unique case (synth_a_input_sel)
      RICD_SEL_AUTO: want_sec = !pv_s2; // [R9]
      RICD_SEL_PIN: want_sec = rs_s2 ? !pv_s2 : 1'b0;
      RICD_SEL_PRI: want_sec = 1'b0;
      default: want_sec = 1'b1;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      use_sec <= 1'b0;
      seen_sec <= 1'b0;
    end
    else
    begin
      use_sec <= want_sec; // [R9]
      // remembers that the secondary was in use, cleared on return only when keep-on is 0
      if (want_sec)
        seen_sec <= 1'b1;
      else if (use_sec && !ctrl.sec_xtal_keep_on)
        seen_sec <= 1'b0; // [R2]
    end
  end
  assign synth_a_use_sec_o = use_sec;
  // buffer stays on while in use or after return when kept on [R3]
  assign sec_xtal_en_o = use_sec || (seen_sec && ctrl.sec_xtal_keep_on);

  // =====================================
  // checks
  bypass_ratio_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    synth_a_m_bypass_o |-> synth_a_m_ratio_o == 6'h01)
    else $error("m bypass ratio wrong"); // [R7]
  ref_ratio_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    !synth_a_ref_bypass_o |-> synth_a_ref_ratio_o > 4'h1)
    else $error("ref ratio wrong"); // [R6]
  b_ratio_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    synth_b_ref_ratio_o == {1'b0, div_o.synth_b_ref_div} + 4'h1)
    else $error("b ratio wrong"); // [R8]
  return_off_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (use_sec && !want_sec && !ctrl.sec_xtal_keep_on ##1
      !use_sec && !ctrl.sec_xtal_keep_on) |-> !sec_xtal_en_o)
    else $error("secondary left on"); // [R2]
  return_keep_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (use_sec && !want_sec && ctrl.sec_xtal_keep_on ##1
      ctrl.sec_xtal_keep_on) |-> sec_xtal_en_o)
    else $error("secondary dropped"); // [R3]
  auto_pref_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (synth_a_input_sel == RICD_SEL_AUTO && pv_s2) ##1
      (synth_a_input_sel == RICD_SEL_AUTO) |-> !use_sec)
    else $error("primary not preferred"); // [R9]
  nv_load_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    nv_load_i |=> ctrl_o == $past(nv_ctrl_i))
    else $error("nv load lost"); // [R10]
  bypass_bit_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (wr_en && !nv_load_i && addr_idx == RICD_CTRL_IDX) |=>
      ctrl_o.ref_mux_bypass == $past(pwdata_i[RICD_BYP_BIT]))
    else $error("bypass bit wrong"); // [R1]
  gain_bits_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (wr_en && !nv_load_i && addr_idx == RICD_CTRL_IDX) |=>
      ctrl_o.sec_buf_gain_sel == $past(pwdata_i[RICD_SGAIN_BIT]) &&
      ctrl_o.pri_buf_gain_sel == $past(pwdata_i[RICD_PGAIN_BIT]))
    else $error("gain bits wrong"); // [R4] [R5]
endmodule

// >>> sim/tb.sv
`timescale 1ns/1ns
`define CHK(n,e,g) begin compares++; if ((g) !== (e)) begin err_total++; \
  $display("unexpected %s exp %0h got %0h", n, e, g); end end
module tb;
  import ricd_pkg::*;
  // ==========================
  // bench signals
  logic sys_clk_i, rst_b_i, psel, pen, pwr, nv_ld, pri_ok, pin;
  logic [7:0] paddr, nvc, nva, nvm, nvb, nvbm, v;
  logic [31:0] pwdata, prdata, rd, wd;
  logic pready, pslverr, serr, use_sec, xen, abyp, mbyp, bbyp, gb;
  logic [3:0] arat, brat;
  logic [5:0] mrat, gr;
  ricd_ctrl_t ctrl;
  ricd_div_t div;
  int err_total, compares;
  ricd_top dut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .nv_load_i(nv_ld), .nv_ctrl_i(nvc), .nv_ardiv_i(nva), .nv_amdiv_i(nvm),
    .nv_brdiv_i(nvb), .nv_bmdiv_i(nvbm), .pri_valid_i(pri_ok),
    .ref_sel_pin_i(pin), .ctrl_o(ctrl), .div_o(div),
    .synth_a_use_sec_o(use_sec), .sec_xtal_en_o(xen),
    .synth_a_ref_bypass_o(abyp), .synth_a_m_bypass_o(mbyp),
    .synth_b_ref_bypass_o(bbyp), .synth_a_ref_ratio_o(arat),
    .synth_a_m_ratio_o(mrat), .synth_b_ref_ratio_o(brat));
  // ==========================
  // tasks
  task automatic results;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // one idle cycle after each transfer, so psel is never set twice at once
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= {a[5:0], 2'h0};
    pwdata <= d;
    @(posedge sys_clk_i);
    pen <= 1'b1;
    n = 0;
    do
    begin
      @(posedge sys_clk_i);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      err_total++;
      results;
    end
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge sys_clk_i);
  endtask
  task automatic wt(input logic s);
    int n;
    n = 0;
    while (use_sec !== s && n < 50)
    begin
      @(posedge sys_clk_i);
      n++;
    end
    if (n >= 50)
    begin
      err_total++;
      results;
    end
  endtask
  // ==========================
  // clock
  initial
  begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end
  // ==========================
  // main sequence
  initial
  begin
    {err_total, compares} = 0;
    {rst_b_i, psel, pen, pwr, nv_ld, paddr, pwdata} = 0;
    {nvc, nva, nvm, nvb, nvbm} = 0;
    pri_ok = 1'b1;
    pin = 1'b1;
    void'($urandom(61));
    repeat (10) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    `CHK("ctrl", RICD_CTRL_RST, ctrl)
    `CHK("div", 16'h0000, div)
    apb(1'b0, RICD_CTRL_IDX, 32'h0);
    `CHK("ctrl rd", 32'h3, rd)
    for (int i = 0; i < 6; i++)
    begin
      wd = $urandom;
      pin <= 1'($urandom);
      apb(1'b1, RICD_CTRL_IDX, wd);
      apb(1'b0, RICD_CTRL_IDX, 32'h0);
      `CHK("ctrl rd", {24'h0, wd[7:0]}, rd)
      `CHK("ctrl", wd[7:0], ctrl)
    end
    // every code of synth A ref, synth A M and synth B ref dividers, bypass at 0 and code+1 beyond
    for (int r = 0; r < 3; r++)
      for (int c = 0; c < ((r == 1) ? 32 : 8); c++)
      begin
        apb(1'b1, RICD_ARDIV_IDX + 8'(r), 32'(c));
        apb(1'b0, RICD_ARDIV_IDX + 8'(r), 32'h0);
        gb = (r == 0) ? abyp : (r == 1) ? mbyp : bbyp;
        gr = (r == 0) ? {2'h0, arat} : (r == 1) ? mrat : {2'h0, brat};
        `CHK("div rd", 32'(c), rd)
        `CHK("bypass", 1'(c == 0), gb)
        `CHK("ratio", 6'(c + 1), gr)
      end
    apb(1'b1, 8'h50, 32'hFF);
    `CHK("slverr", 1'b1, serr)
    // switch away and back in automatic mode, keep-on off then on
    apb(1'b1, RICD_SEL_IDX, 32'(RICD_SEL_AUTO));
    for (int k = 0; k < 2; k++)
    begin
      apb(1'b1, RICD_CTRL_IDX, 32'(k * 4 + 3));
      pri_ok <= 1'b0;
      wt(1'b1);
      `CHK("sec on", 1'b1, xen)
      pri_ok <= 1'b1;
      wt(1'b0);
      `CHK("sec after", 1'(k), xen)
    end
    apb(1'b1, RICD_SEL_IDX, 32'(RICD_SEL_SEC));
    wt(1'b1);
    `CHK("forced sec", 1'b1, use_sec)
    apb(1'b1, RICD_SEL_IDX, 32'(RICD_SEL_PRI));
    wt(1'b0);
    `CHK("forced pri", 1'b0, use_sec)
    nvc <= 8'($urandom);
    nva <= 8'($urandom);
    nvm <= 8'($urandom);
    nvb <= 8'($urandom);
    nvbm <= 8'($urandom);
    nv_ld <= 1'b1;
    @(posedge sys_clk_i);
    nv_ld <= 1'b0;
    @(posedge sys_clk_i);
    `CHK("nv ctrl", nvc, ctrl)
    `CHK("nv div", {nva[2:0], nvm[4:0], nvb[2:0], nvbm[4:0]}, div)
    results;
  end
endmodule
